// File: rtl/dls_regs.sv
// Purpose: line setting register bank behind an APB slave
// Assumes: one clock, pclk at 200 MHz; host keeps reserved bits
// Notes: one wait state on every access
`timescale 1ns/100ps
`include "dls_cfg.svh"
`default_nettype none

module dls_regs #(
  parameter int unsigned HOOK_SLOW_CYC = `DLS_T_SLOW_US * `DLS_CLK_MHZ,
  parameter int unsigned HOOK_MED_CYC = `DLS_T_MED_US * `DLS_CLK_MHZ
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // settings toward the line side
  output dls_pkg::dls_line_cfg_t line_cfg,
  output dls_pkg::dls_monitor_t monitor,
  output logic [4:0] min_loop_ma,
  output logic [11:0] line_bias_mv,
  output dls_pkg::dls_term_kind_t ac_term_kind,
  // hook release timing
  output logic hook_release_busy,
  output logic hook_release_done
);

  // ==========================================
  // decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `DLS_OFF_MON) || (a == `DLS_OFF_HOOK) ||
      (a == `DLS_OFF_TERM) || (a == `DLS_OFF_STAT);
  endfunction

  // gain code to attenuation, base 0 for rx and 18 for tx
  function automatic logic [4:0] atten_db(input logic [1:0] code,
                                          input logic [4:0] base);
    atten_db = base + 5'(code) * 5'h06;
  endfunction

  function automatic logic [31:0] hook_cycles(input logic [1:0] spd);
    if (spd[1]) begin
      hook_cycles = 32'(HOOK_SLOW_CYC);
    end else if (spd[0]) begin
      hook_cycles = 32'(HOOK_MED_CYC);
    end else begin
      hook_cycles = 32'(`DLS_FAST_CYC);
    end
  endfunction

  // ==========================================
  // registers
  logic [7:0] mon_q;
  logic [7:0] hook_q;
  logic [7:0] term_q;
  logic [31:0] hook_cnt_q;
  logic busy_q;
  logic done_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  dls_pkg::dls_monitor_t monitor_q;
  logic [4:0] min_ma_q;
  logic [11:0] bias_mv_q;
  dls_pkg::dls_term_kind_t term_kind_q;

  logic access;
  logic wr_ok;
  logic [31:0] rd_d;

  // ==========================================
  // apb handshake
  // one wait state keeps pready and prdata straight from flops
  assign access = psel && penable;
  assign wr_ok = access && pready_q && pwrite && is_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= access && !pready_q && !is_mapped(paddr);
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      `DLS_OFF_MON: rd_d = {24'h00_0000, mon_q & `DLS_MASK_MON};
      `DLS_OFF_HOOK: rd_d = {24'h00_0000, hook_q & `DLS_MASK_HOOK};
      `DLS_OFF_TERM: rd_d = {24'h00_0000, term_q};
      `DLS_OFF_STAT: rd_d = {31'h0000_0000, busy_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (access && !pready_q && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // ==========================================
  // setting registers
  // reserved hook bit 1 is stored as written; host keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_q <= `DLS_RST_MON;
    end else if (wr_ok && paddr == `DLS_OFF_MON) begin
      mon_q <= pwdata[7:0] & `DLS_MASK_MON;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hook_q <= `DLS_RST_HOOK;
    end else if (wr_ok && paddr == `DLS_OFF_HOOK) begin
      hook_q <= pwdata[7:0] & `DLS_MASK_HOOK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= `DLS_RST_TERM;
    end else if (wr_ok && paddr == `DLS_OFF_TERM) begin
      term_q <= pwdata[7:0];
    end
  end

  // ==========================================
  // hook release timer
  // restarts on every write of the hook register, new speed applies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hook_cnt_q <= 32'h0000_0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (wr_ok && paddr == `DLS_OFF_HOOK) begin
      hook_cnt_q <= hook_cycles(pwdata[`DLS_HOOK_SPD_LSB +: 2]);
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q) begin
      hook_cnt_q <= hook_cnt_q - 32'h0000_0001;
      busy_q <= hook_cnt_q != 32'h0000_0001;
      done_q <= hook_cnt_q == 32'h0000_0001;
    end else begin
      done_q <= 1'b0;
    end
  end

  // ==========================================
  // decoded settings, one cycle behind the registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_q <= '{1'b1, 5'h00, 1'b1, 5'h00};
    end else begin
      monitor_q.rx_mute <= &mon_q[`DLS_MON_RX_LSB +: 2];
      monitor_q.rx_atten_db <= atten_db(mon_q[`DLS_MON_RX_LSB +: 2], 5'h00);
      monitor_q.tx_mute <= &mon_q[`DLS_MON_TX_LSB +: 2];
      monitor_q.tx_atten_db <= atten_db(mon_q[`DLS_MON_TX_LSB +: 2], 5'h12);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_ma_q <= `DLS_RST_MIN_MA;
    end else begin
      min_ma_q <= 5'h0a + {2'h0, term_q[`DLS_TERM_MINI_LSB +: 2], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_mv_q <= `DLS_RST_BIAS_MV;
    end else begin
      unique case (term_q[`DLS_TERM_DCV_LSB +: 2])
        2'h0: bias_mv_q <= 12'hc1c;
        2'h1: bias_mv_q <= 12'hc80;
        2'h2: bias_mv_q <= 12'hd16;
        2'h3: bias_mv_q <= 12'hdac;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_kind_q <= dls_pkg::DLS_TERM_REAL600;
    end else begin
      unique case (term_q[`DLS_TERM_ACT_LSB +: 4])
        4'h0: term_kind_q <= dls_pkg::DLS_TERM_REAL600;
        4'h3: term_kind_q <= dls_pkg::DLS_TERM_GLOBAL_NO_NZ;
        4'h4: term_kind_q <= dls_pkg::DLS_TERM_NZ;
        4'hf: term_kind_q <= dls_pkg::DLS_TERM_GLOBAL;
        default: term_kind_q <= dls_pkg::DLS_TERM_UNDEFINED;
      endcase
    end
  end

  // ==========================================
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign monitor = monitor_q;
  assign min_loop_ma = min_ma_q;
  assign line_bias_mv = bias_mv_q;
  assign ac_term_kind = term_kind_q;
  assign hook_release_busy = busy_q;
  assign hook_release_done = done_q;

  assign line_cfg.rx_monitor_gain = mon_q[`DLS_MON_RX_LSB +: 2];
  assign line_cfg.tx_monitor_gain = mon_q[`DLS_MON_TX_LSB +: 2];
  assign line_cfg.hook_release_speed = hook_q[`DLS_HOOK_SPD_LSB +: 2];
  assign line_cfg.loop_current_limit_en = hook_q[`DLS_HOOK_LOOP_CURRENT_LIMIT_EN_BIT];
  assign line_cfg.ringer_impedance_sel = hook_q[`DLS_HOOK_RZ_BIT];
  assign line_cfg.ring_threshold_sel = hook_q[`DLS_HOOK_RT_BIT];
  assign line_cfg.min_loop_current = term_q[`DLS_TERM_MINI_LSB +: 2];
  assign line_cfg.tip_ring_voltage = term_q[`DLS_TERM_DCV_LSB +: 2];
  assign line_cfg.ac_termination_sel = term_q[`DLS_TERM_ACT_LSB +: 4];

  // ==========================================
  // checks
  chk_rx_mute_code: assert property (@(posedge pclk) disable iff (!presetn)
    &mon_q[3:2] |=> monitor_q.rx_mute)
    else $error("rx monitor not muted for code 11");

  chk_rx_atten_value: assert property (@(posedge pclk) disable iff (!presetn)
    mon_q[3:2] == 2'h2 |=> monitor_q.rx_atten_db == 5'h0c)
    else $error("rx monitor attenuation wrong");

  chk_tx_atten_value: assert property (@(posedge pclk) disable iff (!presetn)
    mon_q[1:0] == 2'h0 |=> monitor_q.tx_atten_db == 5'h12 && !monitor_q.tx_mute)
    else $error("tx monitor attenuation wrong");

  chk_mon_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready_q && !pwrite && paddr == `DLS_OFF_MON |=> prdata_q[7:4] == 4'h0)
    else $error("monitor upper nibble not zero");

  chk_hook_med_time: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `DLS_OFF_HOOK && pwdata[5:4] == 2'h1
    |=> hook_cnt_q == 32'(HOOK_MED_CYC) && busy_q)
    else $error("hook release count not loaded for 3 ms");

  chk_hook_fast_done: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `DLS_OFF_HOOK && pwdata[5:4] == 2'h0 |=> ##1 done_q && !busy_q)
    else $error("fast hook release not done in time");

  chk_loop_current_limit_en_follows: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `DLS_OFF_HOOK |=> line_cfg.loop_current_limit_en == $past(pwdata[3]))
    else $error("current limit enable not written");

  chk_min_loop_ma: assert property (@(posedge pclk) disable iff (!presetn)
    term_q[7:6] == 2'h3 |=> min_ma_q == 5'h10)
    else $error("minimum loop current wrong");

  chk_bias_low: assert property (@(posedge pclk) disable iff (!presetn)
    term_q[5:4] == 2'h0 |=> bias_mv_q == 12'hc1c)
    else $error("bias pin voltage wrong");

  chk_term_nz: assert property (@(posedge pclk) disable iff (!presetn)
    term_q[3:0] == 4'h4 |=> term_kind_q == dls_pkg::DLS_TERM_NZ)
    else $error("nz termination not decoded");

  chk_term_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> term_q == `DLS_RST_TERM && mon_q == `DLS_RST_MON)
    else $error("reset values wrong");

  chk_tx_mute_code: assert property (@(posedge pclk) disable iff (!presetn)
    &mon_q[1:0] |=> monitor_q.tx_mute)
    else $error("tx monitor not muted for code 11");

  chk_rx_atten_zero: assert property (@(posedge pclk) disable iff (!presetn)
    mon_q[3:2] == 2'h0 |=> monitor_q.rx_atten_db == 5'h00 && !monitor_q.rx_mute)
    else $error("rx monitor not at full level");

  chk_mon_reset_mute: assert property (@(posedge pclk)
    $rose(presetn) |-> monitor_q.rx_mute && monitor_q.tx_mute)
    else $error("monitor not muted after reset");

  chk_hook_slow_time: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `DLS_OFF_HOOK && pwdata[5]
    |=> hook_cnt_q == 32'(HOOK_SLOW_CYC) && busy_q)
    else $error("hook release count not loaded for the slow speed");

  chk_hook_end_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && hook_cnt_q == 32'h0000_0001 && !(wr_ok && paddr == `DLS_OFF_HOOK)
    |=> done_q && !busy_q)
    else $error("hook release did not end with done");

  chk_done_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    done_q |=> !done_q)
    else $error("hook release done longer than one cycle");

  chk_rz_follows: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `DLS_OFF_HOOK |=> line_cfg.ringer_impedance_sel == $past(pwdata[2]))
    else $error("ringer impedance select not written");

  chk_rt_follows: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == `DLS_OFF_HOOK |=> line_cfg.ring_threshold_sel == $past(pwdata[0]))
    else $error("ring threshold select not written");

  chk_min_loop_low: assert property (@(posedge pclk) disable iff (!presetn)
    term_q[7:6] == 2'h0 |=> min_ma_q == 5'h0a)
    else $error("lowest minimum loop current wrong");

  chk_bias_high: assert property (@(posedge pclk) disable iff (!presetn)
    term_q[5:4] == 2'h3 |=> bias_mv_q == 12'hdac)
    else $error("highest bias pin voltage wrong");

  chk_term_real600: assert property (@(posedge pclk) disable iff (!presetn)
    term_q[3:0] == 4'h0 |=> term_kind_q == dls_pkg::DLS_TERM_REAL600)
    else $error("real 600 termination not decoded");

endmodule

`default_nettype wire

// File: rtl/dls_cfg.svh
// Purpose: constants of the line setting register bank
// Assumes: 200 MHz pclk, APB byte addresses
// Notes: definitions only
`ifndef DLS_CFG_SVH
`define DLS_CFG_SVH

// ==========================================
// register byte offsets
`define DLS_OFF_MON 8'h00
`define DLS_OFF_HOOK 8'h04
`define DLS_OFF_TERM 8'h08
`define DLS_OFF_STAT 8'h0c

// ==========================================
// field positions
`define DLS_MON_RX_LSB 2
`define DLS_MON_TX_LSB 0
`define DLS_HOOK_SPD_LSB 4
`define DLS_HOOK_LOOP_CURRENT_LIMIT_EN_BIT 3
`define DLS_HOOK_RZ_BIT 2
`define DLS_HOOK_RT_BIT 0
`define DLS_TERM_MINI_LSB 6
`define DLS_TERM_DCV_LSB 4
`define DLS_TERM_ACT_LSB 0
`define DLS_STAT_BUSY_BIT 0

// ==========================================
// reset values and writable masks
`define DLS_RST_MON 8'h0f
`define DLS_RST_HOOK 8'h00
`define DLS_RST_TERM 8'hf0
`define DLS_RST_MIN_MA 5'h10
`define DLS_RST_BIAS_MV 12'hdac
`define DLS_MASK_MON 8'h0f
`define DLS_MASK_HOOK 8'h3f

// ==========================================
// timing
`define DLS_CLK_MHZ 200
`define DLS_T_SLOW_US 20000
`define DLS_T_MED_US 3000
`define DLS_FAST_CYC 1

`endif

// File: rtl/dls_pkg.sv
// Purpose: types of the line setting register bank
// Assumes: nothing
// Notes: constants live in dls_cfg.svh
`default_nettype none
package dls_pkg;

  // ==========================================
  // settings as stored
  typedef struct packed {
    logic [1:0] rx_monitor_gain;
    logic [1:0] tx_monitor_gain;
    logic [1:0] hook_release_speed;
    logic loop_current_limit_en;
    logic ringer_impedance_sel;
    logic ring_threshold_sel;
    logic [1:0] min_loop_current;
    logic [1:0] tip_ring_voltage;
    logic [3:0] ac_termination_sel;
  } dls_line_cfg_t;

  // ==========================================
  // decoded monitor levels, attenuation in dB
  typedef struct packed {
    logic rx_mute;
    logic [4:0] rx_atten_db;
    logic tx_mute;
    logic [4:0] tx_atten_db;
  } dls_monitor_t;

  typedef enum logic [2:0] {
    DLS_TERM_REAL600,
    DLS_TERM_GLOBAL_NO_NZ,
    DLS_TERM_NZ,
    DLS_TERM_GLOBAL,
    DLS_TERM_UNDEFINED
  } dls_term_kind_t;

endpackage
`default_nettype wire

// File: tb/dls_line_model.sv
// Purpose: line-side stand-in that takes up hook releases
// Assumes: settings arrive as steady levels
// Notes: counts releases, keeps the speed used last
`timescale 1ns/100ps
`default_nettype none
module dls_line_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings from the bank
  input wire dls_pkg::dls_line_cfg_t line_cfg,
  input wire logic hook_release_done,
  // observed
  output int releases,
  output logic [1:0] last_speed
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      releases <= 0;
      last_speed <= 2'h0;
    end else if (hook_release_done) begin
      releases <= releases + 1;
      last_speed <= line_cfg.hook_release_speed;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench of the line setting register bank
// Assumes: hook timer shortened by parameters
// Notes: one task per scenario
`timescale 1ns/100ps
`include "dls_cfg.svh"
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  localparam int SLOW = 40;
  localparam int MED = 12;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, done;
  dls_pkg::dls_line_cfg_t line_cfg;
  dls_pkg::dls_monitor_t monitor;
  logic [4:0] min_ma;
  logic [11:0] bias_mv;
  dls_pkg::dls_term_kind_t kind;
  int failures = 0;
  int tests_run = 0;
  int releases;
  logic [1:0] last_speed;
  always #2.5 pclk = ~pclk;
  dls_regs #(.HOOK_SLOW_CYC(SLOW), .HOOK_MED_CYC(MED)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_cfg(line_cfg),
    .monitor(monitor), .min_loop_ma(min_ma), .line_bias_mv(bias_mv), .ac_term_kind(kind),
    .hook_release_busy(busy), .hook_release_done(done));
  dls_line_model far_end (.pclk(pclk), .presetn(presetn), .line_cfg(line_cfg),
    .hook_release_done(done), .releases(releases), .last_speed(last_speed));
  // ==========================================
  // apb master
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(`DLS_OFF_MON, q);
    `CHK("mon reset", 32'h0000000f, q)
    `CHK("mute reset", 2'b11, {monitor.rx_mute, monitor.tx_mute})
    rd(`DLS_OFF_TERM, q);
    `CHK("term reset", 32'h000000f0, q)
    `CHK("min reset", 5'd16, min_ma)
    `CHK("bias reset", 12'd3500, bias_mv)
    `CHK("kind reset", dls_pkg::DLS_TERM_REAL600, kind)
    apb(1'b0, 8'h10, 32'h0, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
  endtask
  task automatic t_mon();
    logic [31:0] q;
    logic [4:0] rx, tx;
    for (int v = 0; v < 16; v++) begin
      rx = 5'(v / 4);
      tx = 5'(v % 4);
      wr(`DLS_OFF_MON, 32'hfffffff0 | 32'(v)); // upper nibble must not stick
      rd(`DLS_OFF_MON, q);
      `CHK("mon rd", 32'(v), q)
      `CHK("rx raw", 2'(v / 4), line_cfg.rx_monitor_gain)
      `CHK("tx raw", 2'(v % 4), line_cfg.tx_monitor_gain)
      `CHK("rx mute", rx == 5'd3, monitor.rx_mute)
      `CHK("tx mute", tx == 5'd3, monitor.tx_mute)
      if (rx != 5'd3) `CHK("rx atten", rx * 5'd6, monitor.rx_atten_db)
      if (tx != 5'd3) `CHK("tx atten", 5'd18 + tx * 5'd6, monitor.tx_atten_db)
    end
  endtask
  task automatic t_hook();
    int lim[4] = '{1, MED, SLOW, SLOW};
    logic [31:0] q, nv;
    int n;
    for (int i = 0; i < 4; i++) begin
      rd(`DLS_OFF_HOOK, q);
      nv = (q & 32'h00000002) | 32'(i << 4) | 32'((i % 2) * 9) | 32'((i / 2) * 4);
      wr(`DLS_OFF_HOOK, nv);
      for (n = 1; n <= SLOW + 5; n++) begin
        @(posedge pclk);
        #1;
        if (done === 1'b1) break;
        `CHK("busy run", 1'b1, busy)
      end
      if (n > SLOW + 5) begin
        failures++;
        finish_test();
      end
      `CHK("hook time", lim[i], n)
      `CHK("busy end", 1'b0, busy)
      rd(`DLS_OFF_STAT, q);
      `CHK("stat idle", 32'h0, q)
      `CHK("loop_current_limit_en", nv[3], line_cfg.loop_current_limit_en)
      `CHK("rz", nv[2], line_cfg.ringer_impedance_sel)
      `CHK("rt", nv[0], line_cfg.ring_threshold_sel)
      rd(`DLS_OFF_HOOK, q);
      `CHK("hook rd", nv, q)
      `CHK("far speed", 2'(i), last_speed)
    end
    `CHK("far releases", 4, releases)
  endtask
  task automatic t_term();
    logic [3:0] act[5] = '{4'h0, 4'h3, 4'h4, 4'hf, 4'h5};
    dls_pkg::dls_term_kind_t kt[5] = '{dls_pkg::DLS_TERM_REAL600,
      dls_pkg::DLS_TERM_GLOBAL_NO_NZ, dls_pkg::DLS_TERM_NZ, dls_pkg::DLS_TERM_GLOBAL,
      dls_pkg::DLS_TERM_UNDEFINED};
    logic [11:0] mv[4] = '{12'd3100, 12'd3200, 12'd3350, 12'd3500};
    logic [31:0] q;
    for (int i = 0; i < 16; i++) begin
      wr(`DLS_OFF_TERM, {24'h0, 2'(i), 2'(i / 4), act[i % 5]});
      rd(`DLS_OFF_TERM, q);
      `CHK("term rd", {24'h0, 2'(i), 2'(i / 4), act[i % 5]}, q)
      `CHK("mini raw", 2'(i), line_cfg.min_loop_current)
      `CHK("dcv raw", 2'(i / 4), line_cfg.tip_ring_voltage)
      `CHK("act raw", act[i % 5], line_cfg.ac_termination_sel)
      `CHK("min ma", 5'd10 + 5'(2 * (i % 4)), min_ma)
      `CHK("bias", mv[i / 4], bias_mv)
      `CHK("kind", kt[i % 5], kind)
    end
  endtask
  // reset in mid-run while the hook timer is busy
  task automatic t_rereset();
    logic [31:0] q;
    wr(`DLS_OFF_MON, 32'h0000_0000);
    wr(`DLS_OFF_TERM, 32'h0000_005a);
    wr(`DLS_OFF_HOOK, 32'h0000_0020);
    rd(`DLS_OFF_STAT, q);
    `CHK("stat busy", 32'h0000_0001, q)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("busy reset", 1'b0, busy)
    presetn <= 1'b1;
    t_reset();
    rd(`DLS_OFF_HOOK, q);
    `CHK("hook reset", 32'h0, q)
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mon();
    t_hook();
    t_term();
    t_rereset();
    finish_test();
  end
endmodule
`default_nettype wire
